/* design/dmf_digital_input_function_mapper.sv */
/*
  Digital input function mapper: eight filtered field inputs, each with a function
  code, mapped onto drive commands, mode selects and user-memory load pulses.
  Assumes the keypad parameter port is driven by core logic on mclk_in and the
  drive-state and setting inputs are synchronous to it.
*/
// Functional notes
// - Each of eight inputs has a function code 0..24; 0 means unused.
// - Factory codes: 1, 4, 0, 20, 21, 22, 0, 0 for inputs one to eight.
// - Local/remote input: low local, high remote; only when source setting is 4.
// - Speed/torque acts only with control type 4; low speed, high torque.
// - Torque mode forces speed regulator to gain 1.00 and zero integral.
// - Back in speed mode, the stored speed gains apply again.
// - Jog-plus and jog-minus act only with control type 5 or 4.
// - Control type not 5: high disables flying start; low re-enables if mode 1/2.
// - Rising edge on load-user-1 loads set 1 if it was saved before.
// - Rising edge on load-user-2 loads set 2 if it was saved before.
// - User-memory loads are rejected while the drive output is enabled.
// - Lock input high refuses all parameter changes; low follows password settings.
// - No-external-alarm input low shows the alarm; clears itself when high.
// - PID auto/manual inputs: low automatic, high manual.
// - Same PID code on several inputs: lowest-numbered input wins.
// - Run/stop acts only while enable and fast-stop inputs are active.
// - General enable acts only while run/stop and fast-stop inputs active.
module dmf_digital_input_function_mapper
  import dmf_pkg::*;
#(
  parameter int N_IN = N_INPUTS,
  parameter int DEBOUNCE = DEBOUNCE_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [N_IN-1:0] control_input_n_in,
  input wire logic param_wr_in,
  input wire logic param_rd_in,
  input wire logic [PNUM_W-1:0] param_num_in,
  input wire logic [PDATA_W-1:0] param_wdata_in,
  input wire logic password_ok_in,
  input wire logic [3:0] control_type_select_in,
  input wire logic [3:0] local_remote_source_in,
  input wire logic [1:0] flying_start_mode_in,
  input wire logic [15:0] speed_prop_gain_in,
  input wire logic [15:0] speed_integral_gain_in,
  input wire logic drive_enabled_in,
  input wire logic user1_saved_in,
  input wire logic user2_saved_in,
  output logic [PDATA_W-1:0] param_rdata_out,
  output logic param_ack_out,
  output logic param_nack_out,
  output logic param_lock_out,
  output logic [N_IN-1:0] input_status_out,
  output logic run_stop_out,
  output logic general_enable_out,
  output logic fast_stop_out,
  output logic direction_select_out,
  output logic local_remote_select_out,
  output logic local_remote_from_input_out,
  output logic inching_command_out,
  output logic ramp2_out,
  output logic torque_mode_out,
  output logic [15:0] speed_kp_out,
  output logic [15:0] speed_ki_out,
  output logic jog_plus_out,
  output logic jog_minus_out,
  output logic flying_start_enable_out,
  output logic load_user1_out,
  output logic load_user2_out,
  output logic load_reject_out,
  output logic fault_reset_out,
  output logic external_alarm_indication_out,
  output logic [2:0] pid_manual_out,
  output logic bypass_mode_out,
  output logic fire_mode_out
);

  logic [N_IN*FUNC_W-1:0] func_sel;
  logic [PNUM_W-1:0] sel_idx;
  logic sel_hit;
  logic write_ok;
  logic lock_now;

  dmf_filt_if #(.N(N_IN)) filt ();

  dmf_input_filter #(
    .N(N_IN),
    .CNT_W(DEBOUNCE_CNT_W),
    .DEBOUNCE(DEBOUNCE)
  ) u_filter (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .raw_in(control_input_n_in),
    .filt(filt)
  );

  // Result bits: 4 found, 3 first level, 2 all high, 1 any high, 0 any rise
  function automatic logic [4:0] scan(input logic [N_IN*FUNC_W-1:0] sel,
                                      input logic [N_IN-1:0] lv,
                                      input logic [N_IN-1:0] rs,
                                      input logic [FUNC_W-1:0] code);
    logic [4:0] r;
    r = 5'b00100;
    // Downward walk so the lowest-numbered input sets the first level last
    for (int i = N_IN - 1; i >= 0; i--) begin
      if (code != FN_UNUSED && sel[i*FUNC_W +: FUNC_W] == code) begin
        r[4] = 1'b1;
        r[3] = lv[i];
        if (!lv[i]) begin
          r[2] = 1'b0;
        end
        if (lv[i]) begin
          r[1] = 1'b1;
        end
        if (rs[i]) begin
          r[0] = 1'b1;
        end
      end
    end
    return r;
  endfunction : scan

  logic [4:0] s_rs, s_ge, s_fs, s_dir, s_lr, s_inch, s_ramp, s_st, s_jp, s_jm;
  logic [4:0] s_alm, s_rst, s_fly, s_lock, s_lu1, s_lu2, s_pm, s_p1, s_p2, s_byp, s_fire;

  always_comb begin
    s_rs = scan(func_sel, filt.level, filt.rise, FN_RUN_STOP);
    s_ge = scan(func_sel, filt.level, filt.rise, FN_GEN_ENABLE);
    s_fs = scan(func_sel, filt.level, filt.rise, FN_FAST_STOP);
    s_dir = scan(func_sel, filt.level, filt.rise, FN_DIRECTION);
    s_lr = scan(func_sel, filt.level, filt.rise, FN_LOCAL_REMOTE_SELECT);
    s_inch = scan(func_sel, filt.level, filt.rise, FN_INCHING);
    s_ramp = scan(func_sel, filt.level, filt.rise, FN_RAMP2);
    s_st = scan(func_sel, filt.level, filt.rise, FN_SPEED_TORQUE);
    s_jp = scan(func_sel, filt.level, filt.rise, FN_JOG_PLUS);
    s_jm = scan(func_sel, filt.level, filt.rise, FN_JOG_MINUS);
    s_alm = scan(func_sel, filt.level, filt.rise, FN_NO_EXT_ALARM);
    s_rst = scan(func_sel, filt.level, filt.rise, FN_FAULT_RESET);
    s_fly = scan(func_sel, filt.level, filt.rise, FN_DISABLE_FLY);
    s_lock = scan(func_sel, filt.level, filt.rise, FN_PARAM_LOCK);
    s_lu1 = scan(func_sel, filt.level, filt.rise, FN_LOAD_USER1);
    s_lu2 = scan(func_sel, filt.level, filt.rise, FN_LOAD_USER2);
    s_pm = scan(func_sel, filt.level, filt.rise, FN_PID_MAIN);
    s_p1 = scan(func_sel, filt.level, filt.rise, FN_PID_EXT1);
    s_p2 = scan(func_sel, filt.level, filt.rise, FN_PID_EXT2);
    s_byp = scan(func_sel, filt.level, filt.rise, FN_BYPASS);
    s_fire = scan(func_sel, filt.level, filt.rise, FN_FIRE);
  end

  // Parameter port decode
  assign sel_idx = param_num_in - PN_FUNC_BASE;
  assign sel_hit = (param_num_in >= PN_FUNC_BASE) && (sel_idx < PNUM_W'(N_IN));
  assign lock_now = s_lock[1];
  assign write_ok = sel_hit && !lock_now && password_ok_in && (param_wdata_in <= PDATA_W'(FUNC_MAX));

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      func_sel <= FUNC_RESET;
    end else if (param_wr_in && write_ok) begin
      func_sel[sel_idx[2:0]*FUNC_W +: FUNC_W] <= param_wdata_in[FUNC_W-1:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      param_ack_out <= 1'b0;
      param_nack_out <= 1'b0;
      param_rdata_out <= '0;
    end else begin
      param_ack_out <= 1'b0;
      param_nack_out <= 1'b0;
      if (param_wr_in) begin
        param_ack_out <= write_ok;
        param_nack_out <= !write_ok;
      end else if (param_rd_in) begin
        if (param_num_in == PN_INPUT_STATUS) begin
          param_rdata_out <= PDATA_W'(filt.level);
          param_ack_out <= 1'b1;
        end else if (sel_hit) begin
          param_rdata_out <= PDATA_W'(func_sel[sel_idx[2:0]*FUNC_W +: FUNC_W]);
          param_ack_out <= 1'b1;
        end else begin
          param_rdata_out <= '0;
          param_nack_out <= 1'b1;
        end
      end
    end
  end

  // Drive commands with mutual permissives
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      run_stop_out <= 1'b0;
      general_enable_out <= 1'b0;
      fast_stop_out <= 1'b0;
      direction_select_out <= 1'b0;
      inching_command_out <= 1'b0;
      ramp2_out <= 1'b0;
      bypass_mode_out <= 1'b0;
      fire_mode_out <= 1'b0;
      fault_reset_out <= 1'b0;
    end else begin
      run_stop_out <= s_rs[4] && s_rs[3] && s_ge[2] && s_fs[2];
      general_enable_out <= s_ge[4] && s_ge[2] && s_rs[2] && s_fs[2];
      fast_stop_out <= s_fs[4] && !s_fs[2];
      direction_select_out <= s_dir[4] && s_dir[3];
      inching_command_out <= s_inch[4] && s_inch[3];
      ramp2_out <= s_ramp[4] && s_ramp[3];
      bypass_mode_out <= s_byp[4] && s_byp[3];
      fire_mode_out <= s_fire[4] && s_fire[3];
      fault_reset_out <= s_rst[0];
    end
  end

  // Mode selects
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      local_remote_select_out <= 1'b0;
      local_remote_from_input_out <= 1'b0;
      pid_manual_out <= '0;
      external_alarm_indication_out <= 1'b0;
      param_lock_out <= 1'b0;
      input_status_out <= '0;
    end else begin
      local_remote_from_input_out <= s_lr[4] && (local_remote_source_in == LR_SRC_INPUT);
      local_remote_select_out <= s_lr[4] && (local_remote_source_in == LR_SRC_INPUT) && s_lr[3];
      pid_manual_out <= {s_p2[4] && s_p2[3], s_p1[4] && s_p1[3], s_pm[4] && s_pm[3]};
      external_alarm_indication_out <= s_alm[4] && !s_alm[2];
      param_lock_out <= lock_now;
      input_status_out <= filt.level;
    end
  end

  // Regulator gain selection
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      torque_mode_out <= 1'b0;
      speed_kp_out <= '0;
      speed_ki_out <= '0;
    end else if (control_type_select_in == CT_SENSORLESS && s_st[4] && s_st[3]) begin
      torque_mode_out <= 1'b1;
      speed_kp_out <= KP_UNITY_X100;
      speed_ki_out <= KI_ZERO;
    end else begin
      torque_mode_out <= 1'b0;
      speed_kp_out <= speed_prop_gain_in;
      speed_ki_out <= speed_integral_gain_in;
    end
  end

  // Jog and flying start
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      jog_plus_out <= 1'b0;
      jog_minus_out <= 1'b0;
      flying_start_enable_out <= 1'b0;
    end else begin
      jog_plus_out <= (control_type_select_in == CT_SENSORLESS || control_type_select_in == CT_ENCODER)
                      && s_jp[4] && s_jp[3];
      jog_minus_out <= (control_type_select_in == CT_SENSORLESS || control_type_select_in == CT_ENCODER)
                       && s_jm[4] && s_jm[3];
      if (control_type_select_in != CT_ENCODER && s_fly[4] && s_fly[3]) begin
        flying_start_enable_out <= 1'b0;
      end else begin
        flying_start_enable_out <= (flying_start_mode_in == FLY_MODE_A) || (flying_start_mode_in == FLY_MODE_B);
      end
    end
  end

  // User-memory load pulses
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      load_user1_out <= 1'b0;
      load_user2_out <= 1'b0;
      load_reject_out <= 1'b0;
    end else begin
      load_user1_out <= s_lu1[0] && !drive_enabled_in && user1_saved_in;
      load_user2_out <= s_lu2[0] && !drive_enabled_in && user2_saved_in;
      load_reject_out <= (s_lu1[0] && (drive_enabled_in || !user1_saved_in))
                         || (s_lu2[0] && (drive_enabled_in || !user2_saved_in));
    end
  end

  AST_FUNC_RANGE: assert property (@(posedge mclk_in) disable iff (rst_in)
    (param_wr_in && param_wdata_in > PDATA_W'(FUNC_MAX)) |=> (param_nack_out && !param_ack_out))
    else $error("Out-of-range function code accepted");

  AST_FACTORY: assert property (@(posedge mclk_in)
    $fell(rst_in) |-> (func_sel == FUNC_RESET))
    else $error("Factory function codes not loaded at reset");

  AST_LOCREM: assert property (@(posedge mclk_in) disable iff (rst_in)
    local_remote_select_out |-> $past(local_remote_source_in == LR_SRC_INPUT && s_lr[3]))
    else $error("Remote selected without input source or high input");

  AST_TORQUE_GAIN: assert property (@(posedge mclk_in) disable iff (rst_in)
    torque_mode_out |-> (speed_kp_out == KP_UNITY_X100 && speed_ki_out == KI_ZERO
                         && $past(control_type_select_in) == CT_SENSORLESS))
    else $error("Torque mode gains wrong");

  AST_SPEED_GAIN: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!torque_mode_out && !$rose(rst_in) && !$past(rst_in)) |-> (speed_kp_out == $past(speed_prop_gain_in)
                          && speed_ki_out == $past(speed_integral_gain_in)))
    else $error("Stored speed gains not restored");

  AST_JOG: assert property (@(posedge mclk_in) disable iff (rst_in)
    (jog_plus_out || jog_minus_out) |-> ($past(control_type_select_in) == CT_SENSORLESS
                                         || $past(control_type_select_in) == CT_ENCODER))
    else $error("Jog honoured in wrong control type");

  AST_FLY: assert property (@(posedge mclk_in) disable iff (rst_in)
    flying_start_enable_out |-> ($past(flying_start_mode_in) == FLY_MODE_A
                                 || $past(flying_start_mode_in) == FLY_MODE_B))
    else $error("Flying start enabled with mode not 1 or 2");

  AST_LOAD_REJECT: assert property (@(posedge mclk_in) disable iff (rst_in)
    ((s_lu1[0] || s_lu2[0]) && drive_enabled_in) |=> (!load_user1_out && !load_user2_out && load_reject_out))
    else $error("User memory loaded while drive enabled");

  AST_LOCK: assert property (@(posedge mclk_in) disable iff (rst_in)
    (param_wr_in && lock_now) |=> (!param_ack_out && param_nack_out))
    else $error("Parameter change accepted while locked");

  AST_ALARM: assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_alm[4] && !s_alm[2]) |=> external_alarm_indication_out)
    else $error("External alarm not shown for low input");

  AST_PID_PRIO: assert property (@(posedge mclk_in) disable iff (rst_in)
    (func_sel[3*FUNC_W +: FUNC_W] == FN_PID_MAIN && func_sel[0 +: FUNC_W] != FN_PID_MAIN
     && func_sel[FUNC_W +: FUNC_W] != FN_PID_MAIN && func_sel[2*FUNC_W +: FUNC_W] != FN_PID_MAIN)
    |=> (pid_manual_out[0] == $past(filt.level[3])))
    else $error("Lowest main PID input does not win");

  AST_RUN_PERMISSIVE: assert property (@(posedge mclk_in) disable iff (rst_in)
    run_stop_out |-> $past(s_ge[2] && s_fs[2] && s_rs[3]))
    else $error("Run command without permissives");

  AST_UNUSED: assert property (@(posedge mclk_in) disable iff (rst_in)
    (func_sel == '0) |=> (!run_stop_out && !general_enable_out && !param_lock_out
                          && pid_manual_out == 3'b000 && !load_reject_out))
    else $error("Unused input had an effect");

endmodule : dmf_digital_input_function_mapper

/* design/dmf_pkg.sv */
/*
  Constants shared by the digital input function mapper: function codes, parameter
  numbers, factory defaults, setting values and timing counts.
  Assumes a 100 MHz core clock.
*/
package dmf_pkg;

  localparam int N_INPUTS = 8;
  localparam int FUNC_W = 8;
  localparam int PNUM_W = 16;
  localparam int PDATA_W = 16;

  // Function codes
  localparam logic [FUNC_W-1:0] FN_UNUSED = 8'h00;
  localparam logic [FUNC_W-1:0] FN_RUN_STOP = 8'h01;
  localparam logic [FUNC_W-1:0] FN_GEN_ENABLE = 8'h02;
  localparam logic [FUNC_W-1:0] FN_FAST_STOP = 8'h03;
  localparam logic [FUNC_W-1:0] FN_DIRECTION = 8'h04;
  localparam logic [FUNC_W-1:0] FN_LOCAL_REMOTE_SELECT = 8'h05;
  localparam logic [FUNC_W-1:0] FN_INCHING = 8'h06;
  localparam logic [FUNC_W-1:0] FN_RAMP2 = 8'h08;
  localparam logic [FUNC_W-1:0] FN_SPEED_TORQUE = 8'h09;
  localparam logic [FUNC_W-1:0] FN_JOG_PLUS = 8'h0a;
  localparam logic [FUNC_W-1:0] FN_JOG_MINUS = 8'h0b;
  localparam logic [FUNC_W-1:0] FN_NO_EXT_ALARM = 8'h0c;
  localparam logic [FUNC_W-1:0] FN_FAULT_RESET = 8'h0e;
  localparam logic [FUNC_W-1:0] FN_DISABLE_FLY = 8'h0f;
  localparam logic [FUNC_W-1:0] FN_PARAM_LOCK = 8'h11;
  localparam logic [FUNC_W-1:0] FN_LOAD_USER1 = 8'h12;
  localparam logic [FUNC_W-1:0] FN_LOAD_USER2 = 8'h13;
  localparam logic [FUNC_W-1:0] FN_PID_MAIN = 8'h14;
  localparam logic [FUNC_W-1:0] FN_PID_EXT1 = 8'h15;
  localparam logic [FUNC_W-1:0] FN_PID_EXT2 = 8'h16;
  localparam logic [FUNC_W-1:0] FN_BYPASS = 8'h17;
  localparam logic [FUNC_W-1:0] FN_FIRE = 8'h18;
  localparam logic [FUNC_W-1:0] FUNC_MAX = 8'h18;

  // Parameter numbers on the keypad parameter port
  localparam logic [PNUM_W-1:0] PN_INPUT_STATUS = 16'h000c;
  localparam logic [PNUM_W-1:0] PN_FUNC_BASE = 16'h0107;

  // Factory function codes, input 1 in the low byte
  localparam logic [N_INPUTS*FUNC_W-1:0] FUNC_RESET = 64'h0000_1615_1400_0401;

  // Setting values
  localparam logic [3:0] CT_SENSORLESS = 4'h4;
  localparam logic [3:0] CT_ENCODER = 4'h5;
  localparam logic [3:0] LR_SRC_INPUT = 4'h4;
  localparam logic [1:0] FLY_MODE_A = 2'h1;
  localparam logic [1:0] FLY_MODE_B = 2'h2;
  localparam logic [15:0] KP_UNITY_X100 = 16'h0064;
  localparam logic [15:0] KI_ZERO = 16'h0000;

  // Input filter timing
  localparam int CLK_MHZ = 100;
  localparam int DEBOUNCE_TIME_US = 100;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * CLK_MHZ;
  localparam int DEBOUNCE_CNT_W = 16;

endpackage : dmf_pkg

/* design/dmf_filt_if.sv */
/*
  Bundle of filtered input levels and rising-edge pulses between the input filter
  and the function mapper.
  Assumes both ends run on the same core clock.
*/
interface dmf_filt_if #(parameter int N = 8);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface : dmf_filt_if

/* design/dmf_input_filter.sv */
/*
  Three-stage synchroniser and debounce filter for N field inputs, with a one-cycle
  rising-edge pulse per clean low-to-high transition.
  Assumes raw inputs are asynchronous; high means +24 V applied.
*/
module dmf_input_filter
  import dmf_pkg::*;
#(
  parameter int N = 8,
  parameter int CNT_W = 16,
  parameter int DEBOUNCE = 10000
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [N-1:0] raw_in,
  dmf_filt_if.src filt
);

  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] sync3;
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [CNT_W-1:0] cnt [N];

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Level moves only after the agreed sample differs for a full debounce time
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      level <= '0;
      rise <= '0;
      for (int i = 0; i < N; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        rise[i] <= 1'b0;
        if (sync2[i] == sync3[i] && sync3[i] != level[i]) begin
          if (cnt[i] == CNT_W'(DEBOUNCE - 1)) begin
            level[i] <= sync3[i];
            rise[i] <= sync3[i];
            cnt[i] <= '0;
          end else begin
            cnt[i] <= cnt[i] + 1'b1;
          end
        end else begin
          cnt[i] <= '0;
        end
      end
    end
  end

  assign filt.level = level;
  assign filt.rise = rise;

endmodule : dmf_input_filter

/* verification/dmf_field_switches.sv */
/*
  Field wiring model: eight 24 V contacts that chatter for a few cycles on every change.
  Assumes the bench sets the wanted levels on rising edges of mclk_in.
*/
module dmf_field_switches (
  input wire logic mclk_in,
  input wire logic [7:0] want_in,
  output logic [7:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] settled = 8'h00;
  logic [7:0] moving = 8'h00;
  logic [1:0] bounce = 2'h0;
  initial level_out = 8'h00;
  // Changed contacts toggle each cycle, then rest at the wanted level
  always @(posedge mclk_in) begin
    if (want_in != settled) begin
      settled <= want_in;
      moving <= want_in ^ settled;
      bounce <= 2'h3;
      level_out <= level_out ^ (want_in ^ settled);
    end else if (bounce == 2'h1) begin
      bounce <= 2'h0;
      level_out <= want_in;
    end else if (bounce != 2'h0) begin
      bounce <= bounce - 2'h1;
      level_out <= level_out ^ moving;
    end
  end
endmodule : dmf_field_switches

/* verification/dmf_digital_input_function_mapper_bench.sv */
/*
  Self-checking bench for the input function mapper, with bouncing field contacts.
  Assumes each parameter strobe is answered one cycle after it is taken.
*/
module dmf_digital_input_function_mapper_bench import dmf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic param_wr_in = 1'b0, param_rd_in = 1'b0, password_ok_in = 1'b1;
  logic [15:0] param_num_in = 16'h0000, param_wdata_in = 16'h0000;
  logic [3:0] control_type_select_in = 4'h4, local_remote_source_in = 4'h4;
  logic [1:0] flying_start_mode_in = 2'h1;
  logic [15:0] speed_prop_gain_in = 16'h0000, speed_integral_gain_in = 16'h0000;
  logic drive_enabled_in = 1'b0, user1_saved_in = 1'b1, user2_saved_in = 1'b0;
  logic [15:0] param_rdata_out, speed_kp_out, speed_ki_out;
  logic param_ack_out, param_nack_out, param_lock_out, local_remote_select_out, torque_mode_out;
  logic jog_plus_out, load_user1_out, load_reject_out, external_alarm_indication_out;
  logic run_stop_out, general_enable_out, fast_stop_out, direction_select_out, local_remote_from_input_out;
  logic jog_minus_out, flying_start_enable_out, load_user2_out;
  logic [7:0] input_status_out, din, want = 8'h00;
  logic [2:0] pid_manual_out;
  logic [17:0] note;
  logic [17:0] note_q[$];
  int mismatches = 0, checked = 0, seed = 57430, n_load = 0, n_rej = 0;
  logic [7:0] fact[8] = '{8'h01, 8'h04, 8'h00, 8'h14, 8'h15, 8'h16, 8'h00, 8'h00};
  logic [7:0] cfg[8] = '{8'h05, 8'h09, 8'h12, 8'h14, 8'h14, 8'h0c, 8'h0a, 8'h11};
  // Run/stop on input one assumes both run/stop sources set to 1; no DC link code used
  logic [7:0] cfg2[8] = '{8'h01, 8'h02, 8'h03, 8'h0b, 8'h13, 8'h0f, 8'h04, 8'h00};

  dmf_digital_input_function_mapper #(.DEBOUNCE(4)) dmf_digital_input_function_mapper_inst (
    .*, .control_input_n_in(din), .inching_command_out(), .ramp2_out(), .fault_reset_out(),
    .bypass_mode_out(), .fire_mode_out());
  dmf_field_switches dmf_field_switches_inst (.mclk_in(mclk_in), .want_in(want), .level_out(din));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // One strobe; the expected answer is noted first
  task automatic access(input logic wr, input logic [15:0] num, input logic [15:0] data,
                        input logic nack, input logic [15:0] exp);
    note_q.push_back({wr, nack, exp});
    param_wr_in <= wr;
    param_rd_in <= ~wr;
    param_num_in <= num;
    param_wdata_in <= data;
    @(posedge mclk_in);
    param_wr_in <= 1'b0;
    param_rd_in <= 1'b0;
    @(posedge mclk_in);
  endtask : access

  task automatic settle();
    repeat (20) @(posedge mclk_in);
  endtask : settle

  always @(posedge mclk_in) begin
    if (param_ack_out === 1'b1 || param_nack_out === 1'b1) begin
      if (note_q.size() == 0) check("unexpected answer", 16'h0001, 16'h0000);
      else begin
        note = note_q.pop_front();
        check("param_nack_out", {15'h0, param_nack_out}, {15'h0, note[16]});
        check("param_ack_out", {15'h0, param_ack_out}, {15'h0, !note[16]});
        if (!note[17]) check("param_rdata_out", param_rdata_out, note[15:0]);
      end
    end
    if (load_user1_out === 1'b1) n_load++;
    if (load_user2_out === 1'b1) n_load++;
    if (load_reject_out === 1'b1) n_rej++;
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    speed_prop_gain_in <= 16'($random(seed));
    speed_integral_gain_in <= 16'($random(seed));
    for (int k = 0; k < 8; k++) access(1'b0, 16'h0107 + 16'(k), 16'h0000, 1'b0, {8'h00, fact[k]});
    access(1'b0, 16'h000c, 16'h0000, 1'b0, 16'h0000);
    access(1'b0, 16'h0100, 16'h0000, 1'b1, 16'h0000);
    access(1'b1, 16'h010f, 16'h0001, 1'b1, 16'h0000);
    access(1'b1, 16'h0107, 16'h0019 + 16'({$random(seed)} % 231), 1'b1, 16'h0000);
    password_ok_in <= 1'b0;
    access(1'b1, 16'h0107, 16'h0005, 1'b1, 16'h0000);
    password_ok_in <= 1'b1;
    access(1'b1, 16'h010e, 16'h0018, 1'b0, 16'h0000);
    access(1'b0, 16'h010e, 16'h0000, 1'b0, 16'h0018);
    for (int k = 0; k < 8; k++) access(1'b1, 16'h0107 + 16'(k), {8'h00, cfg[k]}, 1'b0, 16'h0000);
    for (int k = 0; k < 8; k++) access(1'b0, 16'h0107 + 16'(k), 16'h0000, 1'b0, {8'h00, cfg[k]});
    settle();
    check("alarm", {15'h0, external_alarm_indication_out}, 16'h0001);
    check("kp", speed_kp_out, speed_prop_gain_in);
    want <= 8'h63;
    settle();
    check("remote", {15'h0, local_remote_select_out}, 16'h0001);
    check("lr input", {15'h0, local_remote_from_input_out}, 16'h0001);
    check("torque", {15'h0, torque_mode_out}, 16'h0001);
    check("kp", speed_kp_out, 16'h0064);
    check("ki", speed_ki_out, 16'h0000);
    check("alarm", {15'h0, external_alarm_indication_out}, 16'h0000);
    check("jog", {15'h0, jog_plus_out}, 16'h0001);
    want <= 8'h73;
    settle();
    check("pid", {13'h0, pid_manual_out}, 16'h0000);
    want <= 8'h7b;
    settle();
    check("pid", {13'h0, pid_manual_out}, 16'h0001);
    control_type_select_in <= 4'h0;
    settle();
    check("jog", {15'h0, jog_plus_out}, 16'h0000);
    check("torque", {15'h0, torque_mode_out}, 16'h0000);
    check("ki", speed_ki_out, speed_integral_gain_in);
    want <= 8'h7f;
    settle();
    check("loads", 16'(n_load), 16'h0001);
    drive_enabled_in <= 1'b1;
    want <= 8'h7b;
    settle();
    want <= 8'h7f;
    settle();
    check("loads", 16'(n_load), 16'h0001);
    check("rejects", 16'(n_rej), 16'h0001);
    access(1'b0, 16'h000c, 16'h0000, 1'b0, 16'h007f);
    check("status", {8'h00, input_status_out}, 16'h007f);
    want <= 8'hff;
    settle();
    check("lock", {15'h0, param_lock_out}, 16'h0001);
    access(1'b1, 16'h0107, 16'h0001, 1'b1, 16'h0000);
    want <= 8'h00;
    drive_enabled_in <= 1'b0;
    user2_saved_in <= 1'b1;
    control_type_select_in <= 4'h5;
    settle();
    for (int k = 0; k < 8; k++) access(1'b1, 16'h0107 + 16'(k), {8'h00, cfg2[k]}, 1'b0, 16'h0000);
    want <= 8'h29;
    settle();
    check("fast stop", {15'h0, fast_stop_out}, 16'h0001);
    check("run", {15'h0, run_stop_out}, 16'h0000);
    check("jog minus", {15'h0, jog_minus_out}, 16'h0001);
    check("fly", {15'h0, flying_start_enable_out}, 16'h0001);
    want <= 8'h3f;
    control_type_select_in <= 4'h4;
    settle();
    check("run", {15'h0, run_stop_out}, 16'h0001);
    check("enable", {15'h0, general_enable_out}, 16'h0001);
    check("fly", {15'h0, flying_start_enable_out}, 16'h0000);
    check("loads", 16'(n_load), 16'h0002);
    want <= 8'h7e;
    settle();
    check("enable", {15'h0, general_enable_out}, 16'h0000);
    check("direction", {15'h0, direction_select_out}, 16'h0001);
    for (int k = 0; k < 8; k++) access(1'b1, 16'h0107 + 16'(k), 16'h0000, 1'b0, 16'h0000);
    want <= 8'hff;
    settle();
    check("lock", {15'h0, param_lock_out}, 16'h0000);
    check("run", {15'h0, run_stop_out}, 16'h0000);
    check("pid", {13'h0, pid_manual_out}, 16'h0000);
    check("answers left", 16'(note_q.size()), 16'h0000);
    conclude();
  end
endmodule : dmf_digital_input_function_mapper_bench
